// >>> sbr_dev.sv
// Device end: boot straps, zero-address remap and memory controller config
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Before remap, zero address goes to ROM or NOR0
// - Strap low boots ROM, high boots NOR0
// - After remap, boot devices only at physical addresses
// - After remap, zero goes to enabled tightly coupled RAM
// - Software sets remap bit in word 5
// - Tightly coupled RAMs disabled at reset, software enables
// - Tightly coupled RAMs reachable by CPU core only
// - One cycle latency, two reads above 300MHz
// - Word 5 bit 12 controls read wait
// - Word 4 bit 15 selects mobile SDRAM
// - Word 4 bit 24 selects mobile IO voltage
// - Five data ports plus one register port
// - Default priority: port 0 highest, port 4 lowest
// - Word 4 bits 14:0 reprogram port priority
// - Word 4 bit 22 inserts read pipe stage
// - With pipe, software sets static control 8:6 to 001
// - Static memory interface works in both modes
// - Debug pins select CPU, DSP or both
// - Software enables shared memory before any access
// - DSP shared memory addr 25:24 from page bits
// - Decoder uses full 32-bit address space
// - Unified map except DSP-internal blocks
module sbr_dev
   import sbr_pkg::*;
(
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 resetn,
   // Link to the bus-master side
   sbr_if.dev                        bus,
   // Strap pins, asynchronous to clock
   input  wire logic                 boot_source_select_pin,
   input  wire logic [1:0]           debug_target_select_pins,
   // Memory controller configuration
   output logic                      mobile_sdram_mode,
   output logic                      io_voltage_alt,
   output logic                      read_pipe_en,
   output logic [W4_PRIO_W-1:0]      port_priority,
   // Tightly coupled RAM control
   output logic                      tc_read_wait,
   output logic                      itc_ram_enable,
   output logic                      dtc_ram_enable,
   // System mode
   output logic                      remap_active,
   output logic                      boot_from_nor_bank0,
   output logic                      debug_cpu_en,
   output logic                      debug_dsp_en
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic        boot_s1;
      logic        boot_s2;
      logic [1:0]  dbg_s1;
      logic [1:0]  dbg_s2;
      logic [1:0]  settle;
      logic        taken;
      logic        boot_nor;
      logic [1:0]  dbg_sel;
      logic        dbg_cpu;
      logic        dbg_dsp;
      logic [31:0] w4;
      logic [31:0] w5;
      logic [31:0] dw4;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      sbr_tgt_e    tgt;
      logic [31:0] dsp_map;
      logic        dsp_den;
   } sbr_dev_s;

   sbr_dev_s s_r;
   sbr_dev_s s_nxt;

   // -----------------------------------------------------------------
   // CPU-side decode
   // -----------------------------------------------------------------
   // Full 32-bit compare, so no alias of a window appears higher up
   function automatic sbr_tgt_e cpu_decode(input logic [31:0] a, input logic core,
                                           input logic [31:0] w5, input logic nor_boot);
      sbr_tgt_e t;
      t = TGT_SYS;
      if (sbr_in_win(a, ZERO_BASE, ZERO_SIZE)) begin
         if (!w5[W5_REMAP_BIT]) begin
            t = nor_boot ? TGT_NOR0 : TGT_ROM;
         end else if (core && w5[W5_ITC_EN_BIT] && sbr_in_win(a, ITC_BASE, ITC_SIZE)) begin
            t = TGT_ITC;
         end else if (core && w5[W5_DTC_EN_BIT] && sbr_in_win(a, DTC_BASE, DTC_SIZE)) begin
            t = TGT_DTC;
         end else begin
            t = TGT_NONE;
         end
      end else if (sbr_in_win(a, ROM_BASE, ROM_SIZE)) begin
         t = TGT_ROM;
      end else if (sbr_in_win(a, NOR0_BASE, NOR0_SIZE)) begin
         t = TGT_NOR0;
      end
      cpu_decode = t;
   endfunction

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;

      // Two-stage synchronisers; stage one feeds only stage two
      s_nxt.boot_s1 = boot_source_select_pin;
      s_nxt.boot_s2 = s_r.boot_s1;
      s_nxt.dbg_s1  = debug_target_select_pins;
      s_nxt.dbg_s2  = s_r.dbg_s1;

      // Straps caught once after release; later pin changes ignored
      if (!s_r.taken) begin
         if (s_r.settle == SETTLE_CNT) begin
            s_nxt.taken    = 1'b1;
            s_nxt.boot_nor = s_r.boot_s2;
            s_nxt.dbg_sel  = s_r.dbg_s2;
         end else begin
            s_nxt.settle = s_r.settle + 2'h1;
         end
      end

      // Reserved debug code enables neither target
      s_nxt.dbg_cpu = (s_nxt.dbg_sel == DBG_CPU_ONLY) || (s_nxt.dbg_sel == DBG_BOTH);
      s_nxt.dbg_dsp = (s_nxt.dbg_sel == DBG_DSP_ONLY) || (s_nxt.dbg_sel == DBG_BOTH);

      // APB: answer is ready in the first access cycle
      s_nxt.pready  = 1'b0;
      s_nxt.pslverr = 1'b0;
      if (bus.psel && !bus.penable) begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = '0;
         if (bus.paddr == OFF_CPU_WORD4) begin
            s_nxt.prdata = s_r.w4;
         end else if (bus.paddr == OFF_CPU_WORD5) begin
            s_nxt.prdata = s_r.w5;
         end else if (bus.paddr == OFF_DSP_WORD4) begin
            s_nxt.prdata = s_r.dw4;
         end else if (bus.paddr == OFF_STATUS) begin
            s_nxt.prdata = {26'h0000000, s_r.dbg_sel == 2'h3, s_r.taken,
                            s_r.w5[W5_REMAP_BIT], s_r.dbg_sel, s_r.boot_nor};
            s_nxt.pslverr = bus.pwrite;                  // Status is read-only
         end else begin
            s_nxt.pslverr = 1'b1;                        // Unmapped address
         end
      end

      // Writes land only on the edge where pready is sampled high
      if (bus.psel && bus.penable && s_r.pready && bus.pwrite && !s_r.pslverr) begin
         if (bus.paddr == OFF_CPU_WORD4) begin
            s_nxt.w4 = bus.pwdata;
         end else if (bus.paddr == OFF_CPU_WORD5) begin
            // Remap bit cannot be cleared by software
            s_nxt.w5 = bus.pwdata | (s_r.w5 & REMAP_MASK);
         end else if (bus.paddr == OFF_DSP_WORD4) begin
            s_nxt.dw4 = bus.pwdata;
         end
      end

      // CPU decode, one cycle of latency
      s_nxt.tgt = cpu_decode(bus.cpu_addr, bus.cpu_from_core, s_r.w5, s_r.boot_nor);

      // DSP view: local blocks shifted, shared memory paged
      s_nxt.dsp_map = bus.dsp_addr;
      s_nxt.dsp_den = 1'b0;
      if (sbr_in_win(bus.dsp_addr, DSPL_BASE, DSPL_SIZE)) begin
         s_nxt.dsp_map = DSPL_CPU_BASE + (bus.dsp_addr - DSPL_BASE);
      end else if (sbr_in_win(bus.dsp_addr, SHM0_BASE, SHM_SIZE)) begin
         s_nxt.dsp_map[PAGE_ADDR_LSB +: PAGE_W] = s_r.dw4[DW4_PAGE0_LSB +: PAGE_W];
         s_nxt.dsp_den = !s_r.w5[W5_SHM0_BIT];           // Flag access before enable
      end else if (sbr_in_win(bus.dsp_addr, SHM1_BASE, SHM_SIZE)) begin
         s_nxt.dsp_map[PAGE_ADDR_LSB +: PAGE_W] = s_r.dw4[DW4_PAGE1_LSB +: PAGE_W];
         s_nxt.dsp_den = !s_r.w5[W5_SHM1_BIT];
      end
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_r     <= '0;
         s_r.w4  <= W4_RESET;
         s_r.w5  <= W5_RESET;
         s_r.dw4 <= DW4_RESET;
         s_r.tgt <= TGT_NONE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Outputs, all straight from the state register
   // -----------------------------------------------------------------
   assign bus.prdata         = s_r.prdata;
   assign bus.pready         = s_r.pready;
   assign bus.pslverr        = s_r.pslverr;
   assign bus.cpu_target     = s_r.tgt;
   assign bus.dsp_addr_map   = s_r.dsp_map;
   assign bus.dsp_shm_denied = s_r.dsp_den;

   // Static memory path is never gated by the mode bit
   assign mobile_sdram_mode  = s_r.w4[W4_MOBILE_BIT];
   assign io_voltage_alt     = s_r.w4[W4_IOV_BIT];
   // Needed above 120MHz; static control needs matching setup
   assign read_pipe_en       = s_r.w4[W4_RDPIPE_BIT];
   // Three-bit rank per data port, five ports, lower rank wins
   assign port_priority      = s_r.w4[W4_PRIO_LSB +: W4_PRIO_W];
   // Wait on reads only, for core clocks above 300MHz
   assign tc_read_wait       = s_r.w5[W5_WAIT_BIT];
   assign itc_ram_enable     = s_r.w5[W5_ITC_EN_BIT];
   assign dtc_ram_enable     = s_r.w5[W5_DTC_EN_BIT];
   assign remap_active       = s_r.w5[W5_REMAP_BIT];
   assign boot_from_nor_bank0 = s_r.boot_nor;
   assign debug_cpu_en       = s_r.dbg_cpu;
   assign debug_dsp_en       = s_r.dbg_dsp;

endmodule
`default_nettype wire

// >>> sbr_pkg.sv
// Shared constants, types and helpers for the boot, remap and config block
package sbr_pkg;

   // -----------------------------------------------------------------
   // Register map (one aligned 32-bit word each)
   // -----------------------------------------------------------------
   localparam logic [31:0] OFF_CPU_WORD4 = 32'h0000_0000;
   localparam logic [31:0] OFF_CPU_WORD5 = 32'h0000_0004;
   localparam logic [31:0] OFF_DSP_WORD4 = 32'h0000_0008;
   localparam logic [31:0] OFF_STATUS    = 32'h0000_000C;

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int          W4_PRIO_LSB   = 0;
   localparam int          W4_PRIO_W     = 15;
   localparam int          PRIO_FIELD_W  = 3;
   localparam int          W4_MOBILE_BIT = 15;
   localparam int          W4_RDPIPE_BIT = 22;
   localparam int          W4_IOV_BIT    = 24;
   localparam int          W5_REMAP_BIT  = 0;
   localparam int          W5_ITC_EN_BIT = 1;
   localparam int          W5_DTC_EN_BIT = 2;
   localparam int          W5_SHM0_BIT   = 3;
   localparam int          W5_SHM1_BIT   = 4;
   localparam int          W5_WAIT_BIT   = 12;
   localparam int          DW4_PAGE0_LSB = 0;
   localparam int          DW4_PAGE1_LSB = 2;
   localparam int          PAGE_W        = 2;
   localparam int          PAGE_ADDR_LSB = 24;
   // Port i holds rank i: port 0 highest, port 4 lowest
   localparam logic [31:0] W4_RESET      = 32'h0000_4688;
   localparam logic [31:0] W5_RESET      = 32'h0000_0000;
   localparam logic [31:0] DW4_RESET     = 32'h0000_0000;
   localparam logic [31:0] REMAP_MASK    = 32'h0000_0001;

   // -----------------------------------------------------------------
   // Address windows of the decoder
   // -----------------------------------------------------------------
   localparam logic [31:0] ZERO_BASE     = 32'h0000_0000;
   localparam logic [31:0] ZERO_SIZE     = 32'h0010_0000;
   localparam logic [31:0] ITC_BASE      = 32'h0000_0000;
   localparam logic [31:0] ITC_SIZE      = 32'h0000_2000;
   localparam logic [31:0] DTC_BASE      = 32'h0000_4000;
   localparam logic [31:0] DTC_SIZE      = 32'h0000_4000;
   localparam logic [31:0] ROM_BASE      = 32'h1000_0000;
   localparam logic [31:0] ROM_SIZE      = 32'h0000_2000;
   localparam logic [31:0] NOR0_BASE     = 32'h1100_0000;
   localparam logic [31:0] NOR0_SIZE     = 32'h0100_0000;
   localparam logic [31:0] SHM0_BASE     = 32'h6000_0000;
   localparam logic [31:0] SHM1_BASE     = 32'h6400_0000;
   localparam logic [31:0] SHM_SIZE      = 32'h0400_0000;
   localparam logic [31:0] DSPL_BASE     = 32'hC000_0000;
   localparam logic [31:0] DSPL_SIZE     = 32'h0100_0000;
   localparam logic [31:0] DSPL_CPU_BASE = 32'h8000_0000;

   // Strap sampling waits for the two-stage synchroniser to fill
   localparam logic [1:0]  SETTLE_CNT    = 2'h2;

   // -----------------------------------------------------------------
   // Debug target codes and decode targets
   // -----------------------------------------------------------------
   localparam logic [1:0]  DBG_CPU_ONLY  = 2'h0;
   localparam logic [1:0]  DBG_DSP_ONLY  = 2'h1;
   localparam logic [1:0]  DBG_BOTH      = 2'h2;

   typedef enum logic [5:0] {
      TGT_NONE = 6'h01,
      TGT_ROM  = 6'h02,
      TGT_NOR0 = 6'h04,
      TGT_ITC  = 6'h08,
      TGT_DTC  = 6'h10,
      TGT_SYS  = 6'h20
   } sbr_tgt_e;

   // Window check without overflow at the top of the 4GB space
   function automatic logic sbr_in_win(input logic [31:0] a, input logic [31:0] base,
                                       input logic [31:0] size);
      sbr_in_win = (a >= base) && ((a - base) < size);
   endfunction

endpackage

// >>> sbr_if.sv
// Interface joining the config block to the bus-master side
`timescale 1ns/1ps
`default_nettype none
interface sbr_if;
   import sbr_pkg::*;

   // APB register access
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   // CPU-side address decode
   logic [31:0] cpu_addr;
   logic        cpu_from_core;
   sbr_tgt_e    cpu_target;
   // DSP-side address translation
   logic [31:0] dsp_addr;
   logic [31:0] dsp_addr_map;
   logic        dsp_shm_denied;

   modport dev (
      input  psel, penable, pwrite, paddr, pwdata, cpu_addr, cpu_from_core, dsp_addr,
      output prdata, pready, pslverr, cpu_target, dsp_addr_map, dsp_shm_denied
   );
   modport host (
      output psel, penable, pwrite, paddr, pwdata, cpu_addr, cpu_from_core, dsp_addr,
      input  prdata, pready, pslverr, cpu_target, dsp_addr_map, dsp_shm_denied
   );
endinterface
`default_nettype wire

// >>> sbr_host.sv
// Bus-master end: APB master for config words and decode requester
`timescale 1ns/1ps
`default_nettype none
module sbr_host
   import sbr_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // Link to the config block
   sbr_if.host              bus,
   // Register command port
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire logic [31:0] cmd_addr,
   input  wire logic [31:0] cmd_wdata,
   output logic             cmd_ready,
   output logic             rsp_valid,
   output logic [31:0]      rsp_rdata,
   output logic             rsp_err,
   // Address lookups
   input  wire logic [31:0] look_cpu_addr,
   input  wire logic        look_cpu_core,
   input  wire logic [31:0] look_dsp_addr,
   output sbr_tgt_e         look_cpu_target,
   output logic [31:0]      look_dsp_map,
   output logic             look_dsp_denied
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      HS_IDLE   = 3'h1,
      HS_SETUP  = 3'h2,
      HS_ACCESS = 3'h4
   } sbr_hst_e;

   typedef struct packed {
      sbr_hst_e    st;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
      logic        cmd_ready;
      logic        rsp_valid;
      logic [31:0] rsp_rdata;
      logic        rsp_err;
      logic [31:0] cpu_addr;
      logic        cpu_core;
      logic [31:0] dsp_addr;
      sbr_tgt_e    tgt;
      logic [31:0] dsp_map;
      logic        dsp_den;
   } sbr_hst_s;

   sbr_hst_s s_r;
   sbr_hst_s s_nxt;

   // Master sequence: setup, then access held until pready
   always_comb begin
      s_nxt           = s_r;
      s_nxt.rsp_valid = 1'b0;
      unique case (s_r.st)
         HS_IDLE: begin
            if (cmd_valid && s_r.cmd_ready) begin
               s_nxt.st        = HS_SETUP;
               s_nxt.psel      = 1'b1;
               s_nxt.pwrite    = cmd_write;
               s_nxt.paddr     = cmd_addr;
               s_nxt.pwdata    = cmd_wdata;
               s_nxt.cmd_ready = 1'b0;
            end
         end
         HS_SETUP: begin
            s_nxt.st      = HS_ACCESS;
            s_nxt.penable = 1'b1;
         end
         HS_ACCESS: begin
            // No fixed wait assumed: release only on the pready edge
            if (bus.pready) begin
               s_nxt.st        = HS_IDLE;
               s_nxt.psel      = 1'b0;
               s_nxt.penable   = 1'b0;
               s_nxt.rsp_valid = 1'b1;
               s_nxt.rsp_rdata = bus.prdata;
               s_nxt.rsp_err   = bus.pslverr;
               s_nxt.cmd_ready = 1'b1;
            end
         end
      endcase
      // Lookups are pipelined, one request per cycle
      s_nxt.cpu_addr = look_cpu_addr;
      s_nxt.cpu_core = look_cpu_core;
      s_nxt.dsp_addr = look_dsp_addr;
      s_nxt.tgt      = bus.cpu_target;
      s_nxt.dsp_map  = bus.dsp_addr_map;
      s_nxt.dsp_den  = bus.dsp_shm_denied;
   end

   // State register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_r           <= '0;
         s_r.st        <= HS_IDLE;
         s_r.cmd_ready <= 1'b1;
         s_r.tgt       <= TGT_NONE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign bus.psel          = s_r.psel;
   assign bus.penable       = s_r.penable;
   assign bus.pwrite        = s_r.pwrite;
   assign bus.paddr         = s_r.paddr;
   assign bus.pwdata        = s_r.pwdata;
   assign bus.cpu_addr      = s_r.cpu_addr;
   assign bus.cpu_from_core = s_r.cpu_core;
   assign bus.dsp_addr      = s_r.dsp_addr;
   assign cmd_ready         = s_r.cmd_ready;
   assign rsp_valid         = s_r.rsp_valid;
   assign rsp_rdata         = s_r.rsp_rdata;
   assign rsp_err           = s_r.rsp_err;
   assign look_cpu_target   = s_r.tgt;
   assign look_dsp_map      = s_r.dsp_map;
   assign look_dsp_denied   = s_r.dsp_den;

endmodule
`default_nettype wire

// >>> sbr_props.sv
// Interface-level checker for the boot, remap and config block
`timescale 1ns/1ps
`default_nettype none
module sbr_props
   import sbr_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        resetn,
   // Register bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   // Decode paths
   input wire logic [31:0] cpu_addr,
   input wire logic        cpu_from_core,
   input wire sbr_tgt_e    cpu_target,
   input wire logic [31:0] dsp_addr,
   input wire logic [31:0] dsp_addr_map
);
   // ---------------------------------------------------------------
   // Properties, one clock domain
   // ---------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);

   property p_rdy;
      psel && !penable |=> pready && penable && $stable(paddr);
   endproperty
   a_rdy: assert property (p_rdy)
      else $error("no zero-wait answer");
   property p_one;
      pready |=> !pready;
   endproperty
   a_one: assert property (p_one)
      else $error("ready longer than one cycle");
   property p_ro;
      psel && penable && pwrite && paddr == OFF_STATUS |-> pslverr;
   endproperty
   a_ro: assert property (p_ro)
      else $error("status write not refused");
   property p_rom;
      cpu_addr >= ROM_BASE && cpu_addr - ROM_BASE < ROM_SIZE |=> cpu_target == TGT_ROM;
   endproperty
   a_rom: assert property (p_rom)
      else $error("boot rom not at physical address");
   property p_nor;
      cpu_addr >= NOR0_BASE && cpu_addr - NOR0_BASE < NOR0_SIZE |=> cpu_target == TGT_NOR0;
   endproperty
   a_nor: assert property (p_nor)
      else $error("nor bank not at physical address");
   property p_sys;
      cpu_addr[31:28] == 4'h2 |=> cpu_target == TGT_SYS;
   endproperty
   a_sys: assert property (p_sys)
      else $error("system window misdecoded");
   property p_core;
      !cpu_from_core |=> !(cpu_target inside {TGT_ITC, TGT_DTC});
   endproperty
   a_core: assert property (p_core)
      else $error("coupled ram seen by bus master");
   property p_dspl;
      dsp_addr[31:24] == 8'hC0 |=> dsp_addr_map == {8'h80, $past(dsp_addr[23:0])};
   endproperty
   a_dspl: assert property (p_dspl)
      else $error("dsp local block misplaced");
   property p_page;
      dsp_addr[31:27] == 5'h0C |=> dsp_addr_map[31:26] == $past(dsp_addr[31:26])
         && dsp_addr_map[23:0] == $past(dsp_addr[23:0]);
   endproperty
   a_page: assert property (p_page)
      else $error("shared memory address bits wrong");
endmodule
`default_nettype wire

// >>> system_boot_remap_config_test.sv
// Self-checking bench joining both ends of the config block
`timescale 1ns/1ps
`default_nettype none
module system_boot_remap_config_test;
   import sbr_pkg::*;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic        clock, resetn, cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_err;
   logic        look_cpu_core, look_dsp_denied, boot_pin, mob, iov, pipe, waitc;
   logic        itc_en, dtc_en, remap, nor_boot, dcpu, ddsp;
   logic [31:0] cmd_addr, cmd_wdata, rsp_rdata, look_cpu_addr, look_dsp_addr, look_dsp_map, q;
   logic [14:0] prio;
   logic [1:0]  dbg_pins;
   logic        e;
   sbr_tgt_e    look_cpu_target;
   int          fails, checks;
   sbr_if i_sbr_if ();
   sbr_host i_sbr_host (.clock(clock), .resetn(resetn), .bus(i_sbr_if), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
      .look_cpu_addr(look_cpu_addr), .look_cpu_core(look_cpu_core), .look_dsp_addr(look_dsp_addr),
      .look_cpu_target(look_cpu_target), .look_dsp_map(look_dsp_map),
      .look_dsp_denied(look_dsp_denied));
   sbr_dev i_sbr_dev (.clock(clock), .resetn(resetn), .bus(i_sbr_if),
      .boot_source_select_pin(boot_pin), .debug_target_select_pins(dbg_pins),
      .mobile_sdram_mode(mob), .io_voltage_alt(iov), .read_pipe_en(pipe), .port_priority(prio),
      .tc_read_wait(waitc), .itc_ram_enable(itc_en), .dtc_ram_enable(dtc_en),
      .remap_active(remap), .boot_from_nor_bank0(nor_boot), .debug_cpu_en(dcpu),
      .debug_dsp_en(ddsp));
   sbr_props i_sbr_props (.clock(clock), .resetn(resetn), .psel(i_sbr_if.psel),
      .penable(i_sbr_if.penable), .pwrite(i_sbr_if.pwrite), .paddr(i_sbr_if.paddr),
      .pready(i_sbr_if.pready), .pslverr(i_sbr_if.pslverr), .cpu_addr(i_sbr_if.cpu_addr),
      .cpu_from_core(i_sbr_if.cpu_from_core), .cpu_target(i_sbr_if.cpu_target),
      .dsp_addr(i_sbr_if.dsp_addr), .dsp_addr_map(i_sbr_if.dsp_addr_map));
   // ---------------------------------------------------------------
   // Shared tasks: drive at rising edges, sample at falling edges
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One word over the host command port; bounded wait on the response
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      cmd_valid <= 1'h1;
      cmd_write <= wr;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge clock);
      cmd_valid <= 1'h0;
      for (n = 0; n < 20 && rsp_valid !== 1'h1; n++) @(negedge clock);
      if (n == 20) begin
         fails++;
         summarize();
      end else begin
         q = rsp_rdata;
         e = rsp_err;
      end
   endtask
   // Lookup result lands three edges after the inputs
   task automatic look(input logic [31:0] ca, input logic core, input logic [31:0] da);
      @(posedge clock);
      look_cpu_addr <= ca;
      look_cpu_core <= core;
      look_dsp_addr <= da;
      repeat (3) @(posedge clock);
      @(negedge clock);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset(input logic b, input logic [1:0] d);
      @(posedge clock);
      resetn <= 1'h0;
      boot_pin <= b;
      dbg_pins <= d;
      repeat (10) @(posedge clock);
      resetn <= 1'h1;
      repeat (4) @(posedge clock);
      boot_pin <= ~b; // Late pin change must be ignored
      look(32'h0000_0100, 1'h1, 32'h0);
      chk("nor_boot", b, nor_boot);
      chk("dbg", {!d[0], d[0] ^ d[1]}, {dcpu, ddsp});
      chk("prio", {3'h4, 3'h3, 3'h2, 3'h1, 3'h0}, prio);
      chk("cfg", 32'h0, {mob, iov, pipe, waitc, itc_en, dtc_en, remap});
      chk("zero", b ? TGT_NOR0 : TGT_ROM, look_cpu_target);
      apb(1'h0, OFF_STATUS, 32'h0);
      chk("status", {26'h0, d == 2'h3, 1'h1, 1'h0, d, b}, q);
      $display("reset test done");
   endtask
   task automatic t_config;
      // Pipe on; the bench writes no static control, so 8:6 is not set to 001
      apb(1'h1, OFF_CPU_WORD4, 32'h0140_829C);
      chk("modes", 32'h7, {mob, iov, pipe});
      chk("prio_new", 32'h029C, prio);
      apb(1'h0, OFF_CPU_WORD4, 32'h0);
      chk("w4_read", 32'h0140_829C, q);
      chk("cmd_ready", 32'h1, cmd_ready);
      apb(1'h1, OFF_STATUS, 32'h0);
      chk("status_err", 32'h1, e);
      apb(1'h0, 32'h0000_0010, 32'h0);
      chk("unmapped_err", 32'h1, e);
      $display("config test done");
   endtask
   task automatic t_remap;
      apb(1'h1, OFF_CPU_WORD5, 32'h0000_0001);
      chk("remap", 32'h1, remap);
      look(32'h0, 1'h1, 32'h0);
      chk("zero_off", TGT_NONE, look_cpu_target);
      look(NOR0_BASE, 1'h1, 32'h0);
      chk("nor_phys", TGT_NOR0, look_cpu_target);
      apb(1'h1, OFF_CPU_WORD5, 32'h0000_1007);
      chk("tc_ctl", 32'h7, {waitc, itc_en, dtc_en});
      look(32'h0, 1'h1, 32'h0);
      chk("itc", TGT_ITC, look_cpu_target);
      look(32'h0000_4000, 1'h1, 32'h0);
      chk("dtc", TGT_DTC, look_cpu_target);
      look(32'h0, 1'h0, 32'h0);
      chk("bus_itc", TGT_NONE, look_cpu_target);
      apb(1'h1, OFF_CPU_WORD5, 32'h0);
      chk("sticky", 32'h1, remap);
      $display("remap test done");
   endtask
   task automatic t_dsp;
      apb(1'h1, OFF_DSP_WORD4, 32'h0000_0009);
      apb(1'h1, OFF_CPU_WORD5, 32'h0000_0008);
      look(ROM_BASE, 1'h1, 32'h6000_1234);
      chk("rom_phys", TGT_ROM, look_cpu_target);
      chk("shm0", 32'h6100_1234, look_dsp_map);
      chk("shm0_ok", 32'h0, look_dsp_denied);
      look(32'h2000_0000, 1'h1, 32'h6400_0010);
      chk("sys", TGT_SYS, look_cpu_target);
      chk("shm1", 32'h6600_0010, look_dsp_map);
      chk("shm1_off", 32'h1, look_dsp_denied);
      look(32'h0, 1'h1, 32'hC000_0040);
      chk("dsp_local", 32'h8000_0040, look_dsp_map);
      $display("dsp test done");
   endtask
   // ---------------------------------------------------------------
   // Clock and main sequence
   // ---------------------------------------------------------------
   initial begin
      clock = 1'h0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      {resetn, cmd_valid, cmd_write, look_cpu_core, boot_pin, dbg_pins} = '0;
      {cmd_addr, cmd_wdata, look_cpu_addr, look_dsp_addr} = '0;
      fails = 0;
      checks = 0;
      t_reset(1'h0, 2'h0);
      t_reset(1'h1, 2'h1);
      t_reset(1'h0, 2'h2);
      t_reset(1'h1, 2'h3);
      t_config();
      t_remap();
      t_dsp();
      summarize();
   end
endmodule
`default_nettype wire
